// ### low_power_mode_control.sv
// low-power wait/stop mode controller with peripheral gating
// Summary of operation
// [R1] wait stops the processor clock, bus clock keeps running
// [R2] stop halts both processor clock and bus clock
// [R3] wait entry clears interrupt mask; reset exit sets it, interrupt exit keeps clear
// [R4] stop entry clears interrupt mask; reset exit sets it, external interrupt keeps clear
// [R5] processor clock held after stop until stabilisation delay elapses
// [R6] converter runs in wait; enabled converter interrupt wakes from wait
// [R7] stop makes converter inactive and aborts conversion; resumes after wake
// [R8] enabled break stays active in wait and flags break-in-wait
// [R9] stop makes break inactive, break registers unchanged
// [R10] watchdog counts in wait, resets on timeout when enabled
// [R11] stop removes watchdog input clock and clears watchdog prescaler
// [R12] stop instruction acts only when stop-enable bit is set
// [R13] external interrupt active in wait/stop, unmasked request wakes
// [R14] keyboard interrupt active in wait/stop, unmasked request wakes
// [R15] fine pwm runs in wait, registers blocked, enabled interrupt wakes
// [R16] stop drives both pwm outputs low and clears pwm enable
// [R17] other pwm state kept by stop; pwm stays off until software enables
// [R18] pwm shutdown input keeps detecting during stop
// [R19] enabled voltage monitor active in both modes; its reset ends them (here active and resetting in stop only when i_volt_mon_stop_enable is set)
// [R20] recovery counter holds clocks 4096 cycles, or 32 when short set
// [R21] enabled shutdown low level forces pwm outputs low, clears enable
// [R22] reset or enabled wake request returns to run with processor clock
`timescale 1ns/10ps
module low_power_mode_control
    import lpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_wait_exec,
    input wire logic i_stop_exec,
    input wire logic i_stop_enable,
    input wire logic i_short_recovery_select,
    input wire logic i_converter_irq,
    input wire logic i_converter_irq_en,
    input wire logic i_break_enable,
    input wire logic i_break_event,
    input wire logic i_break_flag_clear,
    input wire logic i_watchdog_enable,
    input wire logic i_watchdog_timeout,
    input wire logic i_ext_irq,
    input wire logic i_ext_irq_mask,
    input wire logic i_keypad_irq,
    input wire logic i_keypad_irq_mask,
    input wire logic i_fine_pwm_irq,
    input wire logic i_fine_pwm_irq_en,
    input wire logic i_fine_pwm_enable_set,
    input wire logic i_fine_pwm_enable_clear,
    input wire logic i_fine_pwm_top_gen,
    input wire logic i_fine_pwm_low_side_gen,
    input wire logic i_fine_pwm_shutdown_en,
    input wire logic i_fine_pwm_shutdown_in,
    input wire logic i_volt_mon_enable,
    input wire logic i_volt_mon_stop_enable,
    input wire logic i_volt_mon_reset_en,
    input wire logic i_volt_mon_low,
    output logic o_cpu_clk_en,
    output logic o_bus_clk_en,
    output logic o_irq_mask,
    output logic o_system_reset,
    output logic o_converter_active,
    output logic o_converter_abort,
    output logic o_break_active,
    output logic o_break_in_wait_flag,
    output logic o_watchdog_input_clock_en,
    output logic o_fine_pwm_enable,
    output logic o_fine_pwm_top_out,
    output logic o_fine_pwm_low_side_out,
    output logic o_fine_pwm_reg_access,
    output logic o_volt_mon_active,
    output logic [WDOG_PRESCALE_W-1:0] o_watchdog_prescaler,
    output lpm_mode_t o_mode
);
    lpm_mode_t mode;
    lpm_mode_t next_mode;
    logic wake_wait;
    logic wake_stop;
    logic reset_req;
    logic stop_go;
    logic recovery_load;
    logic recovery_busy;
    logic shutdown_hit;
    logic fine_pwm_enable;
    logic [WDOG_PRESCALE_W-1:0] wdog_prescale;

    always_comb begin
        stop_go = i_stop_exec && i_stop_enable; // [R12]
        reset_req = (i_watchdog_enable && i_watchdog_timeout && mode != MODE_STOP) // [R10]
                  || (i_volt_mon_enable && i_volt_mon_reset_en && i_volt_mon_low
                      && (mode != MODE_STOP || i_volt_mon_stop_enable)); // [R19]
        wake_stop = (i_ext_irq && !i_ext_irq_mask) // [R13]
                  || (i_keypad_irq && !i_keypad_irq_mask); // [R14]
        wake_wait = wake_stop
                  || (i_converter_irq && i_converter_irq_en) // [R6]
                  || (i_fine_pwm_irq && i_fine_pwm_irq_en) // [R15]
                  || (i_break_enable && i_break_event); // [R8]
        shutdown_hit = i_fine_pwm_shutdown_en && !i_fine_pwm_shutdown_in; // [R18] [R21]
        recovery_load = (mode == MODE_STOP) && wake_stop && !reset_req;
    end

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_RUN: begin
                if (stop_go) begin
                    next_mode = MODE_STOP; // [R2]
                end else if (i_wait_exec) begin
                    next_mode = MODE_WAIT; // [R1]
                end
            end
            MODE_WAIT: begin
                if (reset_req || wake_wait) begin
                    next_mode = MODE_RUN; // [R22]
                end
            end
            MODE_STOP: begin
                if (reset_req) begin
                    next_mode = MODE_RUN; // [R22]
                end else if (wake_stop) begin
                    next_mode = MODE_RECOVER; // [R5]
                end
            end
            MODE_RECOVER: begin
                if (!recovery_busy) begin
                    next_mode = MODE_RUN; // [R22]
                end
            end
            default: begin
                next_mode = MODE_RUN;
            end
        endcase
    end

    stop_recovery_counter u_recovery (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_load(recovery_load),
        .i_short_recovery_select(i_short_recovery_select),
        .o_busy(recovery_busy)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= MODE_RUN;
        end else if (i_ce) begin
            mode <= next_mode;
        end
    end

    // interrupt mask: set by reset, cleared on entry
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_mask <= 1'b1;
        end else if (i_ce) begin
            if (reset_req && (mode == MODE_WAIT || mode == MODE_STOP)) begin
                o_irq_mask <= 1'b1; // [R3] [R4]
            end else if (mode == MODE_RUN && (stop_go || i_wait_exec)) begin
                o_irq_mask <= 1'b0; // [R3] [R4]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_system_reset <= 1'b0;
        end else if (i_ce) begin
            o_system_reset <= reset_req; // [R10] [R19]
        end
    end

    // clock gating follows the next mode
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_clk_en <= 1'b1;
            o_bus_clk_en <= 1'b1;
        end else if (i_ce) begin
            o_cpu_clk_en <= (next_mode == MODE_RUN); // [R1] [R2] [R5] [R22]
            o_bus_clk_en <= (next_mode == MODE_RUN) || (next_mode == MODE_WAIT); // [R1] [R2]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_converter_active <= 1'b1;
            o_converter_abort <= 1'b0;
        end else if (i_ce) begin
            o_converter_active <= (next_mode == MODE_RUN) || (next_mode == MODE_WAIT); // [R6] [R7]
            o_converter_abort <= (mode == MODE_RUN) && (next_mode == MODE_STOP); // [R7]
        end
    end

    // break flag: set wins over clear, registers untouched in stop
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_break_active <= 1'b0;
            o_break_in_wait_flag <= 1'b0;
        end else if (i_ce) begin
            o_break_active <= i_break_enable && (next_mode != MODE_STOP); // [R8] [R9]
            if (i_break_enable && i_break_event && mode == MODE_WAIT) begin
                o_break_in_wait_flag <= 1'b1; // [R8]
            end else if (i_break_flag_clear) begin
                o_break_in_wait_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wdog_prescale <= WDOG_PRESCALE_RESET;
            o_watchdog_input_clock_en <= 1'b1;
        end else if (i_ce) begin
            o_watchdog_input_clock_en <= (next_mode != MODE_STOP); // [R11]
            if (mode == MODE_STOP) begin
                wdog_prescale <= WDOG_PRESCALE_RESET; // [R11]
            end else begin
                wdog_prescale <= wdog_prescale + WDOG_PRESCALE_STEP; // [R10]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_watchdog_prescaler <= WDOG_PRESCALE_RESET;
        end else if (i_ce) begin
            o_watchdog_prescaler <= wdog_prescale;
        end
    end

    // pwm enable: stop and shutdown clear win over software set
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fine_pwm_enable <= 1'b0;
        end else if (i_ce) begin
            if ((mode == MODE_RUN && stop_go) || shutdown_hit) begin
                fine_pwm_enable <= 1'b0; // [R16] [R21] [R17]
            end else if (i_fine_pwm_enable_clear && mode == MODE_RUN) begin
                fine_pwm_enable <= 1'b0;
            end else if (i_fine_pwm_enable_set && mode == MODE_RUN) begin
                fine_pwm_enable <= 1'b1; // [R17]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fine_pwm_enable <= 1'b0;
            o_fine_pwm_top_out <= 1'b0;
            o_fine_pwm_low_side_out <= 1'b0;
            o_fine_pwm_reg_access <= 1'b1;
        end else if (i_ce) begin
            o_fine_pwm_enable <= fine_pwm_enable;
            o_fine_pwm_top_out <= fine_pwm_enable && !shutdown_hit
                                  && mode != MODE_STOP && i_fine_pwm_top_gen; // [R16] [R21]
            o_fine_pwm_low_side_out <= fine_pwm_enable && !shutdown_hit
                                  && mode != MODE_STOP && i_fine_pwm_low_side_gen; // [R16] [R21]
            o_fine_pwm_reg_access <= (next_mode == MODE_RUN); // [R15]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_volt_mon_active <= 1'b0;
            o_mode <= MODE_RUN;
        end else if (i_ce) begin
            o_volt_mon_active <= i_volt_mon_enable
                && (next_mode != MODE_STOP || i_volt_mon_stop_enable); // [R19]
            o_mode <= next_mode;
        end
    end

    sequence s_stop_entry;
        mode == MODE_RUN && stop_go && i_ce;
    endsequence

    sequence s_stop_held;
        o_cpu_clk_en == 1'b0 && o_bus_clk_en == 1'b0;
    endsequence

    a_wait_clocks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R1]
        (mode == MODE_RUN && i_wait_exec && !stop_go && i_ce)
        |=> (!o_cpu_clk_en && o_bus_clk_en))
        else $error("wait entry did not gate only cpu clock");

    a_stop_clocks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R2]
        s_stop_entry |=> s_stop_held)
        else $error("stop entry did not gate both clocks");

    a_mask_cleared: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
        (mode == MODE_RUN && (i_wait_exec || stop_go) && i_ce) |=> !o_irq_mask)
        else $error("mask not cleared on entry");

    a_mask_on_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R4]
        (mode == MODE_STOP && reset_req && i_ce) |=> o_irq_mask)
        else $error("mask not set on reset exit");

    a_recover_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R5]
        (mode == MODE_RECOVER) |-> !o_cpu_clk_en)
        else $error("cpu clock ran during recovery");

    a_stop_gated: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R12]
        (mode == MODE_RUN && i_stop_exec && !i_stop_enable) |=> mode != MODE_STOP)
        else $error("stop taken while disabled");

    a_pwm_off_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R16]
        s_stop_entry |=> ##1 (!o_fine_pwm_enable && !o_fine_pwm_top_out
                              && !o_fine_pwm_low_side_out))
        else $error("pwm still on after stop");

    a_shutdown_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R21]
        (shutdown_hit && i_ce) |=> (!fine_pwm_enable && !o_fine_pwm_low_side_out))
        else $error("shutdown did not disable pwm");

    a_wdog_cleared: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R11]
        (mode == MODE_STOP && i_ce) |=> wdog_prescale == WDOG_PRESCALE_RESET)
        else $error("watchdog prescaler not cleared in stop");

    a_wake_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R22]
        (mode == MODE_WAIT && wake_wait && i_ce) |=> (mode == MODE_RUN && o_cpu_clk_en))
        else $error("wait not ended by wake request");
endmodule : low_power_mode_control

// ### low_power_mode_control_test.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/10ps
module low_power_mode_control_test;
    import lpm_pkg::*;
    logic ref_clk, rst_n, ce, wait_exec, stop_exec, stop_en, short_sel, conv_irq, conv_en;
    logic brk_en, brk_ev, brk_clr, wd_en, wd_to, ext_irq, ext_mask, kp_irq, kp_mask;
    logic pwm_irq, pwm_irq_en, pwm_set, pwm_clr, top_gen, low_gen, shd_en, shd_in;
    logic vm_en, vm_stop_en, vm_rst_en, vm_low, fire;
    logic cpu_clk, bus_clk, mask, sys_rst, conv_act, conv_abort, brk_act, brk_flag, wd_clk;
    logic pwm_en, top_out, low_out, reg_acc, vm_act;
    logic [WDOG_PRESCALE_W-1:0] wd_pre;
    lpm_mode_t mode;
    int bad_count, cmp_count;

    low_power_mode_control dut_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_wait_exec(wait_exec), .i_stop_exec(stop_exec), .i_stop_enable(stop_en),
        .i_short_recovery_select(short_sel), .i_converter_irq(conv_irq),
        .i_converter_irq_en(conv_en), .i_break_enable(brk_en), .i_break_event(brk_ev),
        .i_break_flag_clear(brk_clr), .i_watchdog_enable(wd_en), .i_watchdog_timeout(wd_to),
        .i_ext_irq(ext_irq), .i_ext_irq_mask(ext_mask), .i_keypad_irq(kp_irq),
        .i_keypad_irq_mask(kp_mask), .i_fine_pwm_irq(pwm_irq), .i_fine_pwm_irq_en(pwm_irq_en),
        .i_fine_pwm_enable_set(pwm_set), .i_fine_pwm_enable_clear(pwm_clr),
        .i_fine_pwm_top_gen(top_gen), .i_fine_pwm_low_side_gen(low_gen),
        .i_fine_pwm_shutdown_en(shd_en), .i_fine_pwm_shutdown_in(shd_in),
        .i_volt_mon_enable(vm_en), .i_volt_mon_stop_enable(vm_stop_en),
        .i_volt_mon_reset_en(vm_rst_en), .i_volt_mon_low(vm_low), .o_cpu_clk_en(cpu_clk),
        .o_bus_clk_en(bus_clk), .o_irq_mask(mask), .o_system_reset(sys_rst),
        .o_converter_active(conv_act), .o_converter_abort(conv_abort),
        .o_break_active(brk_act), .o_break_in_wait_flag(brk_flag),
        .o_watchdog_input_clock_en(wd_clk), .o_fine_pwm_enable(pwm_en),
        .o_fine_pwm_top_out(top_out), .o_fine_pwm_low_side_out(low_out),
        .o_fine_pwm_reg_access(reg_acc), .o_volt_mon_active(vm_act),
        .o_watchdog_prescaler(wd_pre), .o_mode(mode));

    wake_source_model ext_src_u (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_fire(fire),
        .i_delay(8'h05), .i_mode(mode), .o_req(ext_irq));

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask : step

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic wait_mode(input lpm_mode_t m, input int bound, output int n);
        n = 0;
        while (mode !== m && n < bound) begin
            step(1);
            n++;
        end
        if (mode !== m) begin
            $display("wrong value mode expected %h seen %h", m, mode);
            bad_count++;
            end_sim();
        end
    endtask : wait_mode

    task automatic pulse(ref logic s);
        s = 1'h1;
        step(1);
        s = 1'h0;
    endtask : pulse

    task automatic t_reset;
        chk("cpu_clk_en", 1, cpu_clk);
        chk("irq_mask", 1, mask);
        chk("wd_clk_en", 1, wd_clk);
        chk("mode", MODE_RUN, mode);
    endtask : t_reset

    task automatic t_wait_wake;
        int n;
        for (int s = 0; s < 4; s++) begin
            pulse(wait_exec);
            chk("cpu_clk_en", 0, cpu_clk);
            chk("bus_clk_en", 1, bus_clk);
            chk("irq_mask", 0, mask);
            chk("reg_access", 0, reg_acc);
            chk("conv_active", 1, conv_act);
            chk("break_active", 1, brk_act);
            chk("vm_active", 1, vm_act);
            if (s == 0) begin
                ext_mask = 1'h1;
                pulse(fire);
                step(8);
                chk("ext_req", 1, ext_irq);
                chk("mode", MODE_WAIT, mode);
                chk("break_flag", 0, brk_flag);
                conv_irq = 1'h1;
            end else if (s == 1) begin
                kp_irq = 1'h1;
            end else if (s == 2) begin
                pwm_irq = 1'h1;
            end else begin
                pulse(brk_ev);
            end
            wait_mode(MODE_RUN, 3, n);
            chk("cpu_clk_en", 1, cpu_clk);
            chk("irq_mask", 0, mask);
            {conv_irq, kp_irq, pwm_irq} = 3'h0;
            step(2);
            ext_mask = 1'h0;
        end
        chk("break_flag", 1, brk_flag);
        pulse(brk_clr);
        step(1);
        chk("break_flag", 0, brk_flag);
    endtask : t_wait_wake

    task automatic t_stop_refused;
        stop_en = 1'h0;
        pulse(stop_exec);
        step(1);
        chk("mode", MODE_RUN, mode);
        stop_en = 1'h1;
    endtask : t_stop_refused

    task automatic t_stop(input logic sh);
        int n;
        int exp;
        exp = sh ? RECOVERY_SHORT_CYCLES : RECOVERY_LONG_CYCLES;
        short_sel = sh;
        pulse(pwm_set);
        step(3);
        chk("pwm_enable", 1, pwm_en);
        pulse(stop_exec);
        chk("mode", MODE_STOP, mode);
        chk("cpu_clk_en", 0, cpu_clk);
        chk("bus_clk_en", 0, bus_clk);
        chk("irq_mask", 0, mask);
        chk("conv_abort", 1, conv_abort);
        chk("wd_clk_en", 0, wd_clk);
        step(1);
        chk("conv_active", 0, conv_act);
        chk("break_active", 0, brk_act);
        chk("pwm_enable", 0, pwm_en);
        chk("top_out", 0, top_out);
        chk("low_out", 0, low_out);
        pulse(fire);
        // prescaler output lags the internal clear by one register stage
        chk("wd_prescaler", 0, wd_pre);
        wait_mode(MODE_RECOVER, 12, n);
        chk("cpu_clk_en", 0, cpu_clk);
        chk("bus_clk_en", 0, bus_clk);
        wait_mode(MODE_RUN, 4200, n);
        chk("recovery_len", exp, n);
        chk("irq_mask", 0, mask);
        chk("cpu_clk_en", 1, cpu_clk);
        chk("pwm_enable", 0, pwm_en);
        chk("conv_active", 1, conv_act);
    endtask : t_stop

    task automatic t_shutdown;
        pulse(pwm_set);
        step(2);
        chk("pwm_enable", 1, pwm_en);
        chk("top_out", 1, top_out);
        chk("low_out", 1, low_out);
        shd_in = 1'h0;
        step(3);
        chk("pwm_enable", 0, pwm_en);
        chk("top_out", 0, top_out);
        chk("low_out", 0, low_out);
        pulse(pwm_set);
        step(2);
        chk("pwm_enable", 0, pwm_en);
        shd_in = 1'h1;
    endtask : t_shutdown

    task automatic t_reset_exit;
        for (int c = 0; c < 3; c++) begin
            if (c == 2) begin
                pulse(stop_exec);
            end else begin
                pulse(wait_exec);
            end
            if (c == 0) begin
                wd_to = 1'h1;
            end else begin
                vm_low = 1'h1;
            end
            step(2);
            chk("system_reset", 1, sys_rst);
            chk("irq_mask", 1, mask);
            chk("mode", MODE_RUN, mode);
            {wd_to, vm_low} = 2'h0;
            rst_n = 1'h0;
            step(1);
            rst_n = 1'h1;
            step(1);
            chk("irq_mask", 1, mask);
            chk("mode", MODE_RUN, mode);
        end
    endtask : t_reset_exit

    initial begin
        bad_count = 0;
        cmp_count = 0;
        {rst_n, wait_exec, stop_exec, short_sel, conv_irq, brk_ev, brk_clr, wd_to} = 8'h00;
        {ext_mask, kp_irq, kp_mask, pwm_irq, pwm_set, pwm_clr, vm_low, fire} = 8'h00;
        {ce, stop_en, conv_en, brk_en, wd_en, pwm_irq_en, top_gen, low_gen} = 8'hff;
        {shd_en, shd_in, vm_en, vm_stop_en, vm_rst_en} = 5'h1f;
        repeat (16) @(posedge ref_clk);
        #10;
        rst_n = 1'h1;
        step(1);
        t_reset();
        t_wait_wake();
        t_stop_refused();
        t_stop(1'h1);
        t_stop(1'h0);
        t_shutdown();
        t_reset_exit();
        end_sim();
    end
endmodule : low_power_mode_control_test

// ### lpm_pkg.sv
// constants and types for the low-power mode controller
package lpm_pkg;
    localparam int unsigned FAST_CLK_MHZ = 10;
    localparam int unsigned RECOVERY_LONG_CYCLES = 4096;
    localparam int unsigned RECOVERY_SHORT_CYCLES = 32;
    localparam int unsigned RECOVERY_W = 12;
    localparam logic [RECOVERY_W-1:0] RECOVERY_LONG_LOAD = 12'hfff;
    localparam logic [RECOVERY_W-1:0] RECOVERY_SHORT_LOAD = 12'h01f;
    localparam logic [RECOVERY_W-1:0] RECOVERY_ZERO = 12'h000;
    localparam logic [RECOVERY_W-1:0] RECOVERY_STEP = 12'h001;
    localparam int unsigned WDOG_PRESCALE_W = 8;
    localparam logic [WDOG_PRESCALE_W-1:0] WDOG_PRESCALE_RESET = 8'h00;
    localparam logic [WDOG_PRESCALE_W-1:0] WDOG_PRESCALE_STEP = 8'h01;
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP,
        MODE_RECOVER
    } lpm_mode_t;
endpackage : lpm_pkg

// ### stop_recovery_counter.sv
// 12-bit stop recovery counter holding the clocks after stop exit
`timescale 1ns/10ps
module stop_recovery_counter
    import lpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic i_short_recovery_select,
    output logic o_busy
);
    logic [RECOVERY_W-1:0] count;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= RECOVERY_ZERO;
        end else if (i_ce) begin
            if (i_load) begin
                count <= i_short_recovery_select ? RECOVERY_SHORT_LOAD
                                                 : RECOVERY_LONG_LOAD; // [R20]
            end else if (count != RECOVERY_ZERO) begin
                count <= count - RECOVERY_STEP;
            end
        end
    end

    always_comb begin
        o_busy = (count != RECOVERY_ZERO);
    end
endmodule : stop_recovery_counter

// ### wake_source_model.sv
// behavioural peripheral that raises a wake request after a delay
`timescale 1ns/10ps
module wake_source_model
    import lpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_fire,
    input wire logic [7:0] i_delay,
    input wire lpm_mode_t i_mode,
    output logic o_req
);
    logic [7:0] count;
    logic armed;

    // request holds until the mode controller has left wait or stop
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed <= 1'h0;
            count <= 8'h00;
            o_req <= 1'h0;
        end else if (i_fire) begin
            armed <= 1'h1;
            count <= i_delay;
        end else if (armed && count != 8'h00) begin
            count <= count - 8'h01;
        end else if (armed) begin
            o_req <= 1'h1;
            armed <= 1'h0;
        end else if (o_req && (i_mode == MODE_RUN || i_mode == MODE_RECOVER)) begin
            o_req <= 1'h0;
        end
    end
endmodule : wake_source_model
